// >>> rtl/wpf_pkg.sv
// package for the wake and power fail control block
package wpf_pkg;
    // register byte offsets; the event banks by address bits 7:4
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_STATE   = 8'h08;
    localparam logic [7:0] OFS_SLEEP   = 8'h0c;
    localparam logic [3:0] OFS_GPE_STS = 4'h1;
    localparam logic [3:0] OFS_GPE_EN  = 4'h2;
    // control bits
    localparam int C_POLICY = 0;
    localparam int C_PCIDIS = 1;
    localparam int C_HNEN   = 2;
    localparam int C_NATIVE = 3;
    localparam int C_DEEPEN = 4;
    localparam int C_SUSACK = 5;
    localparam int C_WOLEN  = 6;
    localparam int C_RTCEN  = 7;
    localparam int CTRL_W   = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    // status bits
    localparam int S_WAKE  = 0;
    localparam int S_PBTN  = 1;
    localparam int S_RTC   = 2;
    localparam int S_CFAIL = 3;
    localparam int S_DFAIL = 4;
    localparam int STS_W   = 5;
    // general-purpose event bits
    localparam int GPE_W     = 128;
    localparam int GPIO_BITS = 72;
    localparam int G_SMBWAK  = 97;
    localparam int G_PCIEPME = 98;
    localparam int G_SPME    = 99;
    localparam int G_WADT    = 100;
    localparam int G_TIER2   = 'h6f;
    localparam logic [7:0] SMB_CMD_WAKE = 8'h01;
    // wake context one-hot {sx, deep, loss, reset}
    localparam logic [3:0] X_SX   = 4'h8;
    localparam logic [3:0] X_DEEP = 4'h4;
    localparam logic [3:0] X_LOSS = 4'h2;
    localparam logic [3:0] X_RST  = 4'h1;
    localparam logic [3:0] M_PBTN = 4'hf;
    localparam logic [3:0] M_RTC  = 4'he;
    localparam logic [3:0] M_GPIO = 4'h8;
    localparam logic [3:0] M_SPME = 4'h8;
    localparam logic [3:0] M_PCIE = 4'he;
    localparam logic [3:0] M_MISC = 4'hb;
    localparam logic [3:0] M_WADT = 4'hc;
    typedef enum logic [2:0] {
        ST_S0, ST_S3, ST_S4, ST_S5, ST_DEEP, ST_G3
    } wpf_state_e;
    typedef struct packed {
        logic core_pg;
        logic deep_pg;
        logic pbtn_n;
        logic battery_low_n_n;
        logic pcie_wake_n;
        logic smbalert_n;
        logic rsm_n;
        logic rtc_alarm;
        logic spme_n;
        logic wake_alarm;
    } wpf_pins_s;
endpackage : wpf_pkg

// >>> rtl/wpf_top.sv
// wake source qualification and power failure handling
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
module wpf_top (
    // clock and rtc-well reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // asynchronous platform pins
    input  wire wpf_pkg::wpf_pins_s  pins,
    // same-clock event sources
    input  wire logic                smbus_cmd_valid,
    input  wire logic [7:0]          smbus_cmd,
    input  wire logic                host_notify_msg,
    input  wire logic                me_wake,
    input  wire logic                wol_wake,
    input  wire logic [3:0]          pcie_pme_msg,
    input  wire logic [71:0]         gpio_wake,
    input  wire logic                gpio_tier2_evt,
    input  wire logic                reset_type_event,
    // register port
    input  wire logic [7:0]          addr,
    input  wire logic [31:0]         wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic [31:0]              rdata,
    // platform outputs
    output wpf_pkg::wpf_state_e      power_state,
    output logic                     suspend_wells_on,
    output logic                     suspend_powerdown_ack,
    output logic                     sci,
    output logic                     wake_pulse
);
    typedef struct packed {
        wpf_pkg::wpf_pins_s          s1;
        wpf_pkg::wpf_pins_s          s2;
        wpf_pkg::wpf_pins_s          prev;
        wpf_pkg::wpf_state_e         state;
        wpf_pkg::wpf_state_e         dsx_entry;
        wpf_pkg::wpf_state_e         pf_state;
        logic                        loss;
        logic                        rst_type;
        logic                        pend;
        logic [wpf_pkg::CTRL_W-1:0]  ctrl;
        logic [wpf_pkg::STS_W-1:0]   sts;
        logic [wpf_pkg::GPE_W-1:0]   gpe_sts;
        logic [wpf_pkg::GPE_W-1:0]   gpe_en;
        logic [31:0]                 rdata;
        logic                        sus_on;
        logic                        sci;
        logic                        wake_pulse;
    } wpf_st_s;

    wpf_st_s     st_r;
    wpf_st_s     st_nxt;
    logic [3:0]  ctx;
    logic        asleep;
    logic        ev;
    logic        pbtn_fall;
    logic        rtc_rise;
    logic        spme_fall;
    logic        pcie_fall;
    logic        alert_fall;
    logic        wadt_rise;
    logic        deep_fall;
    logic        core_fall;
    logic        smb_wake;
    logic        hn_wake;
    logic        wr_gpe_sts;
    logic        wr_gpe_en;
    logic [31:0] ctrl_w;

    function automatic logic allow(input logic [3:0] m,
                                   input logic [3:0] c);
        allow = |(m & c);
    endfunction : allow

    function automatic logic [31:0] gpe_word(
        input logic [wpf_pkg::GPE_W-1:0] v, input logic [1:0] i);
        gpe_word = v[i*32 +: 32];
    endfunction : gpe_word

    function automatic wpf_pkg::wpf_state_e sleep_code(
        input logic [1:0] c);
        case (c)
            2'h1:    sleep_code = wpf_pkg::ST_S3;
            2'h2:    sleep_code = wpf_pkg::ST_S4;
            default: sleep_code = wpf_pkg::ST_S5;
        endcase
    endfunction : sleep_code

    // =========================================================
    // event detection
    always_comb begin
        pbtn_fall  = st_r.prev.pbtn_n & ~st_r.s2.pbtn_n;
        rtc_rise   = ~st_r.prev.rtc_alarm & st_r.s2.rtc_alarm;
        spme_fall  = st_r.prev.spme_n & ~st_r.s2.spme_n;
        pcie_fall  = st_r.prev.pcie_wake_n & ~st_r.s2.pcie_wake_n;
        alert_fall = st_r.prev.smbalert_n & ~st_r.s2.smbalert_n;
        wadt_rise  = ~st_r.prev.wake_alarm & st_r.s2.wake_alarm;
        deep_fall  = st_r.prev.deep_pg & ~st_r.s2.deep_pg;
        core_fall  = st_r.prev.core_pg & ~st_r.s2.core_pg;
        smb_wake   = smbus_cmd_valid
                     && smbus_cmd == wpf_pkg::SMB_CMD_WAKE;
        hn_wake    = host_notify_msg
                     & st_r.ctrl[wpf_pkg::C_HNEN];
        if (st_r.state == wpf_pkg::ST_DEEP) begin
            ctx = wpf_pkg::X_DEEP;
        end else if (st_r.loss) begin
            ctx = wpf_pkg::X_LOSS;
        end else if (st_r.rst_type) begin
            ctx = wpf_pkg::X_RST;
        end else begin
            ctx = wpf_pkg::X_SX;
        end
        asleep = st_r.state == wpf_pkg::ST_S3
                 || st_r.state == wpf_pkg::ST_S4
                 || st_r.state == wpf_pkg::ST_S5
                 || st_r.state == wpf_pkg::ST_DEEP;
        ev = (allow(wpf_pkg::M_PBTN, ctx) & pbtn_fall)
           | (allow(wpf_pkg::M_RTC, ctx) & rtc_rise
              & st_r.ctrl[wpf_pkg::C_RTCEN])
           | (allow(wpf_pkg::M_GPIO, ctx)
              & |(gpio_wake & st_r.gpe_en[71:0]))
           | (allow(wpf_pkg::M_SPME, ctx) & spme_fall
              & st_r.gpe_en[wpf_pkg::G_SPME])
           | (allow(wpf_pkg::M_PCIE, ctx) & pcie_fall
              & ~st_r.ctrl[wpf_pkg::C_PCIDIS])
           | (allow(wpf_pkg::M_MISC, ctx) & alert_fall
              & st_r.ctrl[wpf_pkg::C_NATIVE])
           | (allow(wpf_pkg::M_MISC, ctx) & (smb_wake | hn_wake))
           | (allow(wpf_pkg::M_MISC, ctx) & me_wake)
           | (allow(wpf_pkg::M_MISC, ctx) & wol_wake
              & st_r.ctrl[wpf_pkg::C_WOLEN])
           | (allow(wpf_pkg::M_WADT, ctx) & wadt_rise
              & st_r.gpe_en[wpf_pkg::G_WADT]);
        wr_gpe_sts = wr && addr[7:4] == wpf_pkg::OFS_GPE_STS;
        wr_gpe_en  = wr && addr[7:4] == wpf_pkg::OFS_GPE_EN;
        ctrl_w     = wdata;
        if (wdata[wpf_pkg::C_DEEPEN]) begin
            ctrl_w[wpf_pkg::C_SUSACK] = 1'b0;
        end
    end

    // =========================================================
    // next state
    always_comb begin
        st_nxt            = st_r;
        st_nxt.s1         = pins;
        st_nxt.s2         = st_r.s1;
        st_nxt.prev       = st_r.s2;
        st_nxt.rdata      = 32'h0000_0000;
        st_nxt.wake_pulse = 1'b0;

        // register writes, clears before sets
        if (wr && addr == wpf_pkg::OFS_CTRL) begin
            st_nxt.ctrl = ctrl_w[wpf_pkg::CTRL_W-1:0];
        end
        if (wr && addr == wpf_pkg::OFS_STATUS) begin
            st_nxt.sts = st_r.sts & ~wdata[wpf_pkg::STS_W-1:0];
        end
        if (wr_gpe_sts) begin
            st_nxt.gpe_sts[addr[3:2]*32 +: 32] =
                gpe_word(st_r.gpe_sts, addr[3:2]) & ~wdata;
        end
        if (wr_gpe_en) begin
            st_nxt.gpe_en[addr[3:2]*32 +: 32] = wdata;
        end

        // hardware sets win over software clears
        st_nxt.gpe_sts[71:0] = st_nxt.gpe_sts[71:0]
                               | gpio_wake;
        if (gpio_tier2_evt) begin
            st_nxt.gpe_sts[wpf_pkg::G_TIER2] = 1'b1;
        end
        if (hn_wake) begin
            st_nxt.gpe_sts[wpf_pkg::G_SMBWAK] = 1'b1;
        end
        if (|pcie_pme_msg) begin
            st_nxt.gpe_sts[wpf_pkg::G_PCIEPME] = 1'b1;
        end
        if (spme_fall) begin
            st_nxt.gpe_sts[wpf_pkg::G_SPME] = 1'b1;
        end
        if (pbtn_fall) begin
            st_nxt.sts[wpf_pkg::S_PBTN] = 1'b1;
        end
        if (rtc_rise) begin
            st_nxt.sts[wpf_pkg::S_RTC] = 1'b1;
        end
        if (core_fall) begin
            st_nxt.sts[wpf_pkg::S_CFAIL] = 1'b1;
        end
        if (deep_fall) begin
            st_nxt.sts[wpf_pkg::S_DFAIL] = 1'b1;
            st_nxt.sts[wpf_pkg::S_RTC]   = 1'b0;
        end
        if (!st_r.s2.deep_pg) begin
            st_nxt.sts[wpf_pkg::S_PBTN] = 1'b0;
        end
        if (!st_r.s2.rsm_n) begin
            st_nxt.gpe_sts[wpf_pkg::G_SPME] = 1'b0;
            st_nxt.ctrl[wpf_pkg::C_NATIVE]  = 1'b0;
        end
        if (asleep && ev) begin
            st_nxt.pend = 1'b1;
        end

        // power state sequencing
        case (st_r.state)
            wpf_pkg::ST_S0: begin
                if (reset_type_event) begin
                    st_nxt.state    = wpf_pkg::ST_S5;
                    st_nxt.rst_type = 1'b1;
                end else if (wr && addr == wpf_pkg::OFS_SLEEP
                             && wdata[1:0] != 2'h0) begin
                    st_nxt.loss     = 1'b0;
                    st_nxt.rst_type = 1'b0;
                    st_nxt.pend     = 1'b0;
                    if (wdata[2] && st_r.ctrl[wpf_pkg::C_DEEPEN]) begin
                        st_nxt.state     = wpf_pkg::ST_DEEP;
                        st_nxt.dsx_entry = sleep_code(wdata[1:0]);
                        st_nxt.ctrl[wpf_pkg::C_NATIVE] = 1'b0;
                    end else begin
                        st_nxt.state = sleep_code(wdata[1:0]);
                    end
                end
            end
            wpf_pkg::ST_S3, wpf_pkg::ST_S4, wpf_pkg::ST_S5: begin
                if (st_r.pend && st_r.s2.battery_low_n_n) begin
                    st_nxt.state      = wpf_pkg::ST_S0;
                    st_nxt.pend       = 1'b0;
                    st_nxt.loss       = 1'b0;
                    st_nxt.rst_type   = 1'b0;
                    st_nxt.wake_pulse = 1'b1;
                    st_nxt.sts[wpf_pkg::S_WAKE] = 1'b1;
                end
            end
            wpf_pkg::ST_DEEP: begin
                if (st_r.pend && st_r.s2.battery_low_n_n) begin
                    st_nxt.state = st_r.dsx_entry;
                end
            end
            wpf_pkg::ST_G3: begin
                if (st_r.s2.deep_pg) begin
                    st_nxt.loss = 1'b1;
                    if (!st_r.ctrl[wpf_pkg::C_POLICY]) begin
                        st_nxt.state = wpf_pkg::ST_S0;
                        st_nxt.loss  = 1'b0;
                    end else begin
                        case (st_r.pf_state)
                            wpf_pkg::ST_S4:
                                st_nxt.state = wpf_pkg::ST_S4;
                            wpf_pkg::ST_DEEP:
                                st_nxt.state = wpf_pkg::ST_DEEP;
                            default:
                                st_nxt.state = wpf_pkg::ST_S5;
                        endcase
                    end
                end
            end
            default: st_nxt.state = wpf_pkg::ST_S5;
        endcase

        // power failure overrides sequencing
        if (st_r.state != wpf_pkg::ST_G3 && (deep_fall
            || (core_fall && st_r.state == wpf_pkg::ST_S0))) begin
            st_nxt.state    = wpf_pkg::ST_G3;
            st_nxt.pf_state = st_r.state;
            st_nxt.pend     = 1'b0;
            st_nxt.ctrl[wpf_pkg::C_NATIVE] = 1'b0;
        end

        // read data, one cycle after the strobe
        if (rd) begin
            if (addr == wpf_pkg::OFS_CTRL) begin
                st_nxt.rdata[wpf_pkg::CTRL_W-1:0] = st_r.ctrl;
            end else if (addr == wpf_pkg::OFS_STATUS) begin
                st_nxt.rdata[wpf_pkg::STS_W-1:0] = st_r.sts;
            end else if (addr == wpf_pkg::OFS_STATE) begin
                st_nxt.rdata[2:0]  = st_r.state;
                st_nxt.rdata[6:4]  = st_r.dsx_entry;
                st_nxt.rdata[10:8] = st_r.pf_state;
                st_nxt.rdata[12]   = st_r.pend;
                st_nxt.rdata[13]   = st_r.loss;
                st_nxt.rdata[14]   = st_r.rst_type;
            end else if (addr[7:4] == wpf_pkg::OFS_GPE_STS) begin
                st_nxt.rdata = gpe_word(st_r.gpe_sts, addr[3:2]);
            end else if (addr[7:4] == wpf_pkg::OFS_GPE_EN) begin
                st_nxt.rdata = gpe_word(st_r.gpe_en, addr[3:2]);
            end
        end

        st_nxt.sus_on = st_nxt.state != wpf_pkg::ST_DEEP
                        && st_nxt.state != wpf_pkg::ST_G3;
        st_nxt.sci    = |(st_nxt.gpe_sts & st_nxt.gpe_en);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r           <= '0;
            st_r.state     <= wpf_pkg::ST_S5;
            st_r.dsx_entry <= wpf_pkg::ST_S5;
            st_r.pf_state  <= wpf_pkg::ST_S5;
            st_r.ctrl      <= wpf_pkg::CTRL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata                 = st_r.rdata;
    assign power_state           = st_r.state;
    assign suspend_wells_on      = st_r.sus_on;
    assign suspend_powerdown_ack = st_r.ctrl[wpf_pkg::C_SUSACK];
    assign sci                   = st_r.sci;
    assign wake_pulse            = st_r.wake_pulse;

    // =========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_pend_ok;
        st_r.pend && st_r.s2.battery_low_n_n && asleep
        && st_r.state != wpf_pkg::ST_DEEP;
    endsequence
    sequence s_woken;
        st_r.state == wpf_pkg::ST_S0 && st_r.wake_pulse;
    endsequence

    property p_wake_status;
        wake_pulse |-> st_r.sts[wpf_pkg::S_WAKE];
    endproperty
    a_wake_status: assert property (p_wake_status)
        else $error("wake without wake status");

    property p_battery_low_n;
        asleep && !st_r.s2.battery_low_n_n |=> st_r.state != wpf_pkg::ST_S0;
    endproperty
    a_battery_low_n: assert property (p_battery_low_n)
        else $error("woke while battery low");

    property p_pend;
        s_pend_ok and !deep_fall |=> s_woken;
    endproperty
    a_pend: assert property (p_pend)
        else $error("latched wake not served");

    property p_deep_fail;
        deep_fall |=> st_r.sts[wpf_pkg::S_DFAIL]
                      && !st_r.sts[wpf_pkg::S_RTC];
    endproperty
    a_deep_fail: assert property (p_deep_fail)
        else $error("deep fail flags wrong");

    property p_core_fail;
        core_fall |=> st_r.sts[wpf_pkg::S_CFAIL];
    endproperty
    a_core_fail: assert property (p_core_fail)
        else $error("core fail flag missing");

    property p_pbtn;
        !st_r.s2.deep_pg |=> !st_r.sts[wpf_pkg::S_PBTN];
    endproperty
    a_pbtn: assert property (p_pbtn)
        else $error("button status kept in g3");

    property p_wells;
        st_r.state == wpf_pkg::ST_DEEP |-> !suspend_wells_on;
    endproperty
    a_wells: assert property (p_wells)
        else $error("suspend wells on in deep sleep");

    property p_excl;
        st_r.ctrl[wpf_pkg::C_DEEPEN] |-> !suspend_powerdown_ack;
    endproperty
    a_excl: assert property (p_excl)
        else $error("deep sleep and ack both on");

    property p_policy;
        st_r.state == wpf_pkg::ST_G3 && st_r.s2.deep_pg
        && st_r.ctrl[wpf_pkg::C_POLICY] && !deep_fall
        && st_r.pf_state inside {wpf_pkg::ST_S0, wpf_pkg::ST_S3}
        |=> st_r.state == wpf_pkg::ST_S5 && st_r.loss;
    endproperty
    a_policy: assert property (p_policy)
        else $error("wrong return state after g3");

    property p_pcie_pme;
        |pcie_pme_msg |=> st_r.gpe_sts[wpf_pkg::G_PCIEPME]
                          ##1 (sci || !st_r.gpe_en[wpf_pkg::G_PCIEPME]
                               || !$past(st_r.gpe_en[wpf_pkg::G_PCIEPME]));
    endproperty
    a_pcie_pme: assert property (p_pcie_pme)
        else $error("pcie pme status or sci missing");
endmodule : wpf_top

// >>> test/wake_and_power_fail_control_bench.sv
// self-checking bench for the wake and power fail block
`timescale 1ns/10ps
module wake_and_power_fail_control_bench;
    logic clock = 0, nrst = 0, wr = 0, rd = 0, rd_d = 0;
    logic press = 0, deep_off = 0, bat_low = 0, pw = 0, wol = 0, rst_ev = 0;
    logic smbus_cmd_valid = 0, host_notify_msg = 0, me_wake = 0;
    logic gpio_tier2_evt = 0;
    logic [7:0] smbus_cmd = 0, addr = 0;
    logic [3:0] pcie_pme_msg = 0;
    logic [71:0] gpio_wake = 0;
    logic [31:0] wdata = 0, rdata;
    logic [63:0] exq[$];
    wpf_pkg::wpf_pins_s pins;
    wpf_pkg::wpf_state_e power_state;
    logic wells, ack, sci, wake_pulse;
    int failures = 0, num_checks = 0, wakes = 0, cycles = 0, idx, k;
    // ==========================================
    // clock, model and block
    always #25 clock = ~clock;
    wpf_platform u_plat (.press(press), .deep_off(deep_off),
        .bat_low(bat_low), .pcie_wake(pw), .pins(pins));
    wpf_top u_dut (.clock(clock), .nrst(nrst), .pins(pins),
        .smbus_cmd_valid(smbus_cmd_valid), .smbus_cmd(smbus_cmd),
        .host_notify_msg(host_notify_msg), .me_wake(me_wake),
        .wol_wake(wol), .pcie_pme_msg(pcie_pme_msg),
        .gpio_wake(gpio_wake), .gpio_tier2_evt(gpio_tier2_evt),
        .reset_type_event(rst_ev), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .power_state(power_state),
        .suspend_wells_on(wells), .suspend_powerdown_ack(ack),
        .sci(sci), .wake_pulse(wake_pulse));
    // ==========================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // read data stand one cycle after the strobe; pair with oldest note
    always @(posedge clock) begin
        rd_d <= rd;
        cycles++;
        if (wake_pulse === 1'b1) wakes++;
        if (rd_d === 1'b1 && exq.size() > 0) begin
            check(rdata & exq[0][31:0], exq[0][63:32]);
            void'(exq.pop_front());
        end
        if (cycles > 20000) begin
            failures++;
            stop_test();
        end
    end
    // ==========================================
    // bus and event tasks
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        exq.push_back({e & m, m});
        @(posedge clock);
        rd <= 1'b1; addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : rd_reg
    task automatic wait_state(input wpf_pkg::wpf_state_e s);
        int n;
        for (n = 0; n < 200 && power_state !== s; n++) @(posedge clock);
        check(32'(power_state), 32'(s));
    endtask : wait_state
    task automatic fire(input int e);
        @(posedge clock);
        case (e)
            0: me_wake <= 1'b1;
            1: begin smbus_cmd_valid <= 1'b1; smbus_cmd <= 8'h01; end
            2: pw <= 1'b1;
            3: press <= 1'b1;
            5: wol <= 1'b1;
            default: host_notify_msg <= 1'b1;
        endcase
        @(posedge clock);
        {me_wake, smbus_cmd_valid, host_notify_msg, wol} <= 4'h0;
        repeat (5) @(posedge clock);
        {pw, press} <= 2'h0;
    endtask : fire
    task automatic sleep3;
        wr_reg(wpf_pkg::OFS_SLEEP, 32'h1);
        wait_state(wpf_pkg::ST_S3);
    endtask : sleep3
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(78749));
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        rd_reg(wpf_pkg::OFS_STATE, 32'h333, 32'h7ff);
        rd_reg(wpf_pkg::OFS_CTRL, 32'h0, 32'hff);
        fire(0);
        wait_state(wpf_pkg::ST_S0);
        check(wakes, 1);
        rd_reg(wpf_pkg::OFS_STATUS, 32'h1, 32'h1);
        for (k = 0; k < 5; k++) begin
            if (k == 4) wr_reg(wpf_pkg::OFS_CTRL, 32'h4);
            sleep3();
            if (k == 1) begin
                @(posedge clock);
                smbus_cmd_valid <= 1'b1; smbus_cmd <= 8'h02;
                @(posedge clock);
                smbus_cmd_valid <= 1'b0;
                repeat (8) @(posedge clock);
                check(32'(power_state), 32'(wpf_pkg::ST_S3));
            end
            fire(k);
            wait_state(wpf_pkg::ST_S0);
            check(wakes, k + 2);
            if (k == 2) rd_reg(8'h1c, 32'h0, 32'hffffffff);
        end
        rd_reg(8'h1c, 32'h2, 32'h2);
        bat_low <= 1'b1;
        sleep3();
        fire(0);
        repeat (20) @(posedge clock);
        check(32'(power_state), 32'(wpf_pkg::ST_S3));
        bat_low <= 1'b0;
        wait_state(wpf_pkg::ST_S0);
        wr_reg(8'h1c, 32'hffffffff);
        @(posedge clock);
        pcie_pme_msg <= 4'h4;
        @(posedge clock);
        pcie_pme_msg <= 4'h0;
        rd_reg(8'h1c, 32'h4, 32'hffffffff);
        check(sci, 1'b0);
        wr_reg(8'h2c, 32'h4);
        repeat (2) @(posedge clock);
        check(sci, 1'b1);
        wr_reg(8'h1c, 32'h4);
        repeat (2) @(posedge clock);
        check(sci, 1'b0);
        idx = $urandom % 72;
        @(posedge clock);
        gpio_wake[idx] <= 1'b1; gpio_tier2_evt <= 1'b1;
        @(posedge clock);
        gpio_wake <= '0; gpio_tier2_evt <= 1'b0;
        rd_reg(8'(8'h10 + 4 * (idx / 32)), 32'h1 << (idx % 32),
               32'h1 << (idx % 32));
        rd_reg(8'h1c, 32'h8000, 32'h8000);
        wr_reg(wpf_pkg::OFS_CTRL, 32'h30);
        rd_reg(wpf_pkg::OFS_CTRL, 32'h10, 32'h30);
        check(ack, 1'b0);
        wr_reg(wpf_pkg::OFS_SLEEP, 32'h6);
        wait_state(wpf_pkg::ST_DEEP);
        check(wells, 1'b0);
        fire(0);
        check(32'(power_state), 32'(wpf_pkg::ST_DEEP));
        fire(2);
        wait_state(wpf_pkg::ST_S0);
        rd_reg(wpf_pkg::OFS_STATE, 32'h20, 32'h70);
        @(posedge clock);
        rst_ev <= 1'b1;
        @(posedge clock);
        rst_ev <= 1'b0;
        wait_state(wpf_pkg::ST_S5);
        fire(2);
        check(32'(power_state), 32'(wpf_pkg::ST_S5));
        fire(0);
        wait_state(wpf_pkg::ST_S0);
        wr_reg(wpf_pkg::OFS_CTRL, 32'h42);
        sleep3();
        fire(2);
        check(32'(power_state), 32'(wpf_pkg::ST_S3));
        fire(5);
        wait_state(wpf_pkg::ST_S0);
        wr_reg(wpf_pkg::OFS_CTRL, 32'h1);
        deep_off <= 1'b1;
        wait_state(wpf_pkg::ST_G3);
        check(wells, 1'b0);
        deep_off <= 1'b0;
        wait_state(wpf_pkg::ST_S5);
        rd_reg(wpf_pkg::OFS_STATUS, 32'h18, 32'h1e);
        wr_reg(wpf_pkg::OFS_CTRL, 32'h0);
        deep_off <= 1'b1;
        wait_state(wpf_pkg::ST_G3);
        deep_off <= 1'b0;
        wait_state(wpf_pkg::ST_S0);
        check(wells, 1'b1);
        stop_test();
    end
endmodule : wake_and_power_fail_control_bench

// >>> test/wpf_platform.sv
// platform model: power rails, power button and wake pins
`timescale 1ns/10ps
module wpf_platform (
    // requests from the bench
    input  wire logic               press,
    input  wire logic               deep_off,
    input  wire logic               bat_low,
    input  wire logic               pcie_wake,
    // pins seen by the block
    output wpf_pkg::wpf_pins_s      pins
);
    // ==========================================
    // rail and pin levels
    // core rail cannot stay up without the deep well
    always_comb begin
        pins.core_pg     = ~deep_off;
        pins.deep_pg     = ~deep_off;
        pins.pbtn_n      = ~press;
        pins.battery_low_n_n    = ~bat_low;
        pins.pcie_wake_n = ~pcie_wake;
        pins.smbalert_n  = 1'b1;
        pins.rsm_n       = ~deep_off;
        pins.rtc_alarm   = 1'b0;
        pins.spme_n      = 1'b1;
        pins.wake_alarm  = 1'b0;
    end
endmodule : wpf_platform
